/* File: clock_fanout_consts.vh */
`ifndef CLOCK_FANOUT_CONSTS_VH
`define CLOCK_FANOUT_CONSTS_VH

// serial bus identity and direction
`define SLAVE_ADDR 7'h69
`define DIR_READ 1'b1

// byte count returned first on a read
`define READ_BYTE_COUNT 8'h03

// power-up contents of the three enable latches (all outputs enabled)
`define OE_LOW_RESET 8'hff
`define OE_MID_RESET 8'hff
`define OE_HIGH_RESET 8'hff

// filler returned past the last latch byte
`define READ_FILLER 8'hff

// number of outputs and latch bytes
`define NUM_CLK_OUT 13
`define NUM_LATCH 3

// field positions inside the latch bytes
`define OE_LOW_UPPER 7:6
`define OE_LOW_LOWER 3:0
`define OE_MID_UPPER 7:4
`define OE_MID_LOWER 1:0
`define OE_HIGH_BIT 6

// bit counting on the serial side
`define BITS_PER_BYTE 4'h8
`define BIT_MSB 7

// byte sequence positions within a transfer
`define WR_IDX_FIRST_DATA 3'h2
`define WR_IDX_LAST_DATA 3'h4
`define RD_IDX_COUNT 3'h0
`define RD_IDX_LAST_DATA 3'h3
`define IDX_SATURATE 3'h7

`endif

/* File: clock_fanout_i2c_output_enable.v */
`timescale 1ns/10ps
`include "clock_fanout_consts.vh"

module clock_fanout_i2c_output_enable (
    input wire core_clk, // system clock, 100 MHz
    input wire srst, // synchronous reset, active high
    input wire bufClkIn, // clock to be fanned out
    input wire serialClkIn, // bus clock from the master
    input wire serial_data_pin, // bus data level seen on the wire
    output reg [12:0] clkOut_r, // gated clock copies
    output reg sdaOut_r, // data pin drive value, always low
    output reg sdaOutEnN_r // data pin enable, low while pulling down
);

    // sequencer states; ST_WAIT parks the slave after a foreign address or a
    // master not-acknowledge until the next start or stop
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_ACK = 3'h2;
    localparam ST_WRITE = 3'h3;
    localparam ST_READ = 3'h4;
    localparam ST_MACK = 3'h5;
    localparam ST_WAIT = 3'h6;

    // samplers, filtered levels and their one-cycle delayed copies
    reg [2:0] sclSync_r;
    reg [2:0] sdaSync_r;
    reg [2:0] bufSync_r;
    reg sclF_r;
    reg sdaF_r;
    reg bufF_r;
    reg sclPrev_r;
    reg sdaPrev_r;
    // sequencer registers and their next values
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [3:0] bitCnt_r;
    reg [3:0] bitCnt_nxt;
    reg [7:0] shift_r;
    reg [7:0] shift_nxt;
    reg [2:0] byteIdx_r;
    reg [2:0] byteIdx_nxt;
    reg readDir_r;
    reg readDir_nxt;
    reg drive_r;
    reg drive_nxt;
    reg masterAck_r;
    reg masterAck_nxt;
    // the three enable latches and the write strobe into them
    reg [7:0] latch_r [0:2];
    reg latchWe;
    reg [1:0] latchSel;
    reg [7:0] txByte;
    // decoded bus events, gate vector and next byte position
    wire sclRise;
    wire sclFall;
    wire startEv;
    wire stopEv;
    wire [12:0] gateVec;
    wire [2:0] nextIdx;

    // three stage samplers; a level is accepted only once stages two and three
    // agree, which filters single-cycle glitches at the cost of ~40 ns latency,
    // negligible against a 5 us bus half period
    always @(posedge core_clk) begin
        if (srst) begin
            sclSync_r <= 3'h7;
            sdaSync_r <= 3'h7;
            bufSync_r <= 3'h0;
            sclF_r <= 1'b1;
            sdaF_r <= 1'b1;
            bufF_r <= 1'b0;
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end else begin
            sclSync_r <= {sclSync_r[1:0], serialClkIn};
            sdaSync_r <= {sdaSync_r[1:0], serial_data_pin};
            bufSync_r <= {bufSync_r[1:0], bufClkIn};
            if (sclSync_r[1] == sclSync_r[2]) begin
                sclF_r <= sclSync_r[2];
            end
            if (sdaSync_r[1] == sdaSync_r[2]) begin
                sdaF_r <= sdaSync_r[2];
            end
            if (bufSync_r[1] == bufSync_r[2]) begin
                bufF_r <= bufSync_r[2];
            end
            sclPrev_r <= sclF_r;
            sdaPrev_r <= sdaF_r;
        end
    end

    // bus events from the filtered levels
    // a start or stop needs the clock high on both samples, so data that moves
    // in the low phase is never taken for either
    assign sclRise = sclF_r & ~sclPrev_r;
    assign sclFall = ~sclF_r & sclPrev_r;
    assign startEv = sclF_r & sclPrev_r & ~sdaF_r & sdaPrev_r;
    assign stopEv = sclF_r & sclPrev_r & sdaF_r & ~sdaPrev_r;

    // byte index saturates so long transfers never wrap onto a latch
    // a write past the last latch is still acknowledged and simply discarded
    assign nextIdx = (byteIdx_r == `IDX_SATURATE) ? byteIdx_r : byteIdx_r + 3'h1;

    // byte to send for the current read position
    // positions past the last latch read as filler instead of wrapping
    always @* begin
        txByte = `READ_FILLER;
        if (byteIdx_r == `RD_IDX_COUNT) begin
            txByte = `READ_BYTE_COUNT;
        end else if (byteIdx_r <= `RD_IDX_LAST_DATA) begin
            txByte = latch_r[byteIdx_r[1:0] - 2'h1];
        end
    end

    // bus slave sequencer
    always @* begin
        state_nxt = state_r;
        bitCnt_nxt = bitCnt_r;
        shift_nxt = shift_r;
        byteIdx_nxt = byteIdx_r;
        readDir_nxt = readDir_r;
        drive_nxt = drive_r;
        masterAck_nxt = masterAck_r;
        latchWe = 1'b0;
        latchSel = 2'h0;
        if (startEv) begin
            // a start, repeated or not, always reopens address reception
            state_nxt = ST_ADDR;
            bitCnt_nxt = 4'h0;
            byteIdx_nxt = 3'h0;
            drive_nxt = 1'b0;
        end else if (stopEv) begin
            state_nxt = ST_IDLE;
            drive_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    drive_nxt = 1'b0;
                end
                ST_ADDR, ST_WRITE: begin
                    // eight bits shift in on rising edges; the ninth clock is the acknowledge
                    if (sclRise && bitCnt_r != `BITS_PER_BYTE) begin
                        shift_nxt = {shift_r[6:0], sdaF_r};
                        bitCnt_nxt = bitCnt_r + 4'h1;
                    end else if (sclFall && bitCnt_r == `BITS_PER_BYTE) begin
                        bitCnt_nxt = 4'h0;
                        if (state_r == ST_ADDR) begin
                            if (shift_r[7:1] == `SLAVE_ADDR) begin
                                readDir_nxt = (shift_r[0] == `DIR_READ);
                                drive_nxt = 1'b1;
                                state_nxt = ST_ACK;
                            end else begin
                                state_nxt = ST_WAIT;
                            end
                        end else begin
                            // first two bytes are acked but never stored
                            if (byteIdx_r >= `WR_IDX_FIRST_DATA &&
                                    byteIdx_r <= `WR_IDX_LAST_DATA) begin
                                latchWe = 1'b1;
                                latchSel = byteIdx_r[1:0] - 2'h2;
                            end
                            byteIdx_nxt = nextIdx;
                            drive_nxt = 1'b1;
                            state_nxt = ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    // release after the acknowledge clock, then send or receive
                    if (sclFall) begin
                        if (readDir_r) begin
                            shift_nxt = txByte;
                            drive_nxt = ~txByte[`BIT_MSB];
                            bitCnt_nxt = 4'h1;
                            state_nxt = ST_READ;
                        end else begin
                            drive_nxt = 1'b0;
                            state_nxt = ST_WRITE;
                        end
                    end
                end
                ST_READ: begin
                    // the next bit goes out on each falling edge so data never moves while
                    // the clock is high; the master samples it in the high phase
                    if (sclFall) begin
                        if (bitCnt_r == `BITS_PER_BYTE) begin
                            drive_nxt = 1'b0;
                            byteIdx_nxt = nextIdx;
                            state_nxt = ST_MACK;
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            drive_nxt = ~shift_r[6];
                            bitCnt_nxt = bitCnt_r + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    // master not-acknowledge ends the read after a whole byte
                    if (sclRise) begin
                        masterAck_nxt = ~sdaF_r;
                    end else if (sclFall) begin
                        if (masterAck_r) begin
                            shift_nxt = txByte;
                            drive_nxt = ~txByte[`BIT_MSB];
                            bitCnt_nxt = 4'h1;
                            state_nxt = ST_READ;
                        end else begin
                            state_nxt = ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    // parked: only a start or stop, handled above, moves on from here
                    drive_nxt = 1'b0;
                end
                default: begin
                    state_nxt = ST_IDLE;
                    drive_nxt = 1'b0;
                end
            endcase
        end
    end

    // sequencer state
    // everything moves on the core clock; the bus clock is only ever sampled
    always @(posedge core_clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            bitCnt_r <= 4'h0;
            shift_r <= 8'h00;
            byteIdx_r <= 3'h0;
            readDir_r <= 1'b0;
            drive_r <= 1'b0;
            masterAck_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bitCnt_r <= bitCnt_nxt;
            shift_r <= shift_nxt;
            byteIdx_r <= byteIdx_nxt;
            readDir_r <= readDir_nxt;
            drive_r <= drive_nxt;
            masterAck_r <= masterAck_nxt;
        end
    end

    // enable latches; every bit is stored whole, reserved ones included
    // a byte cut short by a stop never raises the strobe, so it is dropped whole
    always @(posedge core_clk) begin
        if (srst) begin
            latch_r[0] <= `OE_LOW_RESET;
            latch_r[1] <= `OE_MID_RESET;
            latch_r[2] <= `OE_HIGH_RESET;
        end else if (latchWe) begin
            latch_r[latchSel] <= shift_r;
        end
    end

    // open-drain data pin: drive value is fixed low, only the enable moves
    // the enable follows the next drive value so the pin moves with drive_r
    always @(posedge core_clk) begin
        if (srst) begin
            sdaOut_r <= 1'b0;
            sdaOutEnN_r <= 1'b1;
        end else begin
            sdaOut_r <= 1'b0;
            sdaOutEnN_r <= ~drive_nxt;
        end
    end

    // output gate map; bits not listed here drive nothing
    // unused and reserved latch bits stay readable but reach no output
    assign gateVec = {latch_r[2][`OE_HIGH_BIT],
                      latch_r[1][`OE_MID_UPPER], latch_r[1][`OE_MID_LOWER],
                      latch_r[0][`OE_LOW_UPPER], latch_r[0][`OE_LOW_LOWER]};

    // one flop per output keeps the copies aligned; the copy is the sampled
    // input clock, so it only tracks inputs well below half the core rate
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_CLK_OUT; gi = gi + 1) begin : gOut
            always @(posedge core_clk) begin
                if (srst) begin
                    clkOut_r[gi] <= 1'b0;
                end else begin
                    clkOut_r[gi] <= gateVec[gi] & bufF_r;
                end
            end
        end
    endgenerate

endmodule // clock_fanout_i2c_output_enable

/* File: clock_fanout_i2c_output_enable_asserts.sv */
`timescale 1ns/10ps
module clock_fanout_i2c_output_enable_chk (
    input wire core_clk, // system clock
    input wire srst, // synchronous reset
    input wire bufClkIn, // clock being fanned out
    input wire serialClkIn, // bus clock
    input wire serial_data_pin, // resolved bus data
    input wire [12:0] clkOut_r, // gated copies
    input wire sdaOut_r, // data drive value
    input wire sdaOutEnN_r // data enable, low drives
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // steps of a bus clock high phase
    sequence sclRise; $rose(serialClkIn); endsequence
    sequence holdData; $stable(sdaOutEnN_r)[*5]; endsequence
    sequence standLow; (!sdaOutEnN_r)[*8]; endsequence

    drive_low_a: assert property (sdaOut_r == 1'b0) else $error("data drive value not low");
    reset_idle_a: assert property (disable iff (1'b0) srst |=> clkOut_r == 13'h0 && sdaOutEnN_r)
        else $error("outputs not idle after reset");
    out_low_a: assert property ((!bufClkIn)[*7] |-> clkOut_r == 13'h0)
        else $error("output high while source low");
    follow_rise_a: assert property (|(clkOut_r & ~$past(clkOut_r)) |->
        $past(bufClkIn, 3) || $past(bufClkIn, 4) || $past(bufClkIn, 5)) else $error("output rose alone");
    sda_change_a: assert property ($changed(sdaOutEnN_r) |->
        !$past(serialClkIn, 1) && !$past(serialClkIn, 3)) else $error("data moved with clock high");
    hold_high_a: assert property (sclRise |=> holdData)
        else $error("data not held over clock high");
    ack_stand_a: assert property ($fell(sdaOutEnN_r) |=> standLow)
        else $error("data drive too short");
    no_false_start_a: assert property (serialClkIn && $fell(serial_data_pin) |-> sdaOutEnN_r)
        else $error("slave made a start");
endmodule // clock_fanout_i2c_output_enable_chk

bind clock_fanout_i2c_output_enable clock_fanout_i2c_output_enable_chk u_chk (
    .core_clk(core_clk), .srst(srst), .bufClkIn(bufClkIn), .serialClkIn(serialClkIn),
    .serial_data_pin(serial_data_pin), .clkOut_r(clkOut_r), .sdaOut_r(sdaOut_r),
    .sdaOutEnN_r(sdaOutEnN_r));

/* File: bus_master_model.sv */
`timescale 1ns/10ps
module bus_master_model (
    input wire clk, // pacing clock
    input wire sdaLine, // resolved data wire
    output logic scl, // bus clock to the slave
    output logic pullLow // high while pulling data low
);
    initial begin
        scl = 1'b1;
        pullLow = 1'b0;
    end
    // move only just after a clock edge
    task w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // data falls while the clock is high
    task start;
        pullLow = 1'b1;
        w(5);
        scl = 1'b0;
    endtask
    // release data and raise the clock so the next start is a repeated one
    task rstart;
        w(5);
        pullLow = 1'b0;
        w(5);
        scl = 1'b1;
        w(6);
    endtask
    task stop;
        w(5);
        pullLow = 1'b1;
        w(5);
        scl = 1'b1;
        w(6);
        pullLow = 1'b0;
        w(10);
    endtask
    // nine bits of 10 low and 6 high cycles, 160 ns; long low gives the slave room
    task xb(input logic [7:0] d, input logic ackIn, output logic [7:0] r, output logic a);
        for (int i = 8; i >= 0; i--) begin
            w(5);
            pullLow = (i > 0) ? !d[i-1] : !ackIn;
            w(5);
            scl = 1'b1;
            w(5);
            if (i > 0) r[i-1] = sdaLine;
            else a = sdaLine;
            w(1);
            scl = 1'b0;
        end
    endtask
endmodule // bus_master_model

/* File: clock_fanout_i2c_output_enable_tb_top.sv */
`timescale 1ns/10ps
module clock_fanout_i2c_output_enable_tb_top;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic bufClkIn = 1'b0;
    wire sdaLine;
    wire scl;
    wire pullLow;
    wire [12:0] clkOut;
    wire sdaOut;
    wire sdaOutEnN;
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    logic [7:0] rb;
    logic kb;
    always #5 core_clk = ~core_clk;
    // wired-and data line with pull-up
    assign sdaLine = !(pullLow || sdaOutEnN === 1'b0);
    // source clock, 16 cycle period
    always begin
        repeat (8) @(posedge core_clk);
        #1 bufClkIn = ~bufClkIn;
    end
    clock_fanout_i2c_output_enable u_clock_fanout_i2c_output_enable (.core_clk(core_clk),
        .srst(srst), .bufClkIn(bufClkIn), .serialClkIn(scl), .serial_data_pin(sdaLine),
        .clkOut_r(clkOut), .sdaOut_r(sdaOut), .sdaOutEnN_r(sdaOutEnN));
    bus_master_model u_bus_master_model (.clk(core_clk), .sdaLine(sdaLine), .scl(scl),
        .pullLow(pullLow));
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("checked %0d, fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // latches {byte0,byte1,byte2} onto the thirteen outputs
    function logic [12:0] om(input logic [23:0] l);
        return {l[6], l[15:12], l[9:8], l[23:22], l[19:16]};
    endfunction
    // an output that ever goes high over 40 cycles is enabled
    task seeOut(input logic [23:0] l);
        logic [12:0] s;
        s = 13'h0;
        repeat (40) @(posedge core_clk) s = s | clkOut;
        chk(16'(s), 16'(om(l)));
    endtask
    task wr(input logic [7:0] a, input int n, input logic [39:0] d, input logic k0);
        logic [7:0] r;
        logic k;
        u_bus_master_model.start();
        u_bus_master_model.xb(a, 1'b1, r, k);
        chk(16'(k), 16'(k0));
        for (int i = 0; i < n; i++) begin
            u_bus_master_model.xb(d[39-8*i -: 8], 1'b1, r, k);
            chk(16'(k), 16'h0);
        end
        u_bus_master_model.stop();
    endtask
    // count, three latches, then filler, last one refused by the master
    task rd(input logic [23:0] l);
        logic [39:0] e;
        logic [7:0] r;
        logic k;
        e = {8'h03, l, 8'hff};
        u_bus_master_model.start();
        u_bus_master_model.xb(8'hd3, 1'b1, r, k);
        chk(16'(k), 16'h0);
        for (int i = 0; i < 5; i++) begin
            u_bus_master_model.xb(8'hff, i == 4, r, k);
            chk(16'(r), 16'(e[39-8*i -: 8]));
        end
        u_bus_master_model.stop();
        chk(16'(sdaOut), 16'h0);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        #1 srst = 1'b0;
        u_bus_master_model.w(5);
        rd(24'hffffff);
        seeOut(24'hffffff);
        $display("defaults test done");
        wr(8'hd2, 5, {16'h0003, 24'h8a5240}, 1'b0);
        rd(24'h8a5240);
        seeOut(24'h8a5240);
        $display("gating test done");
        wr(8'hd2, 5, {16'h0003, 24'h350c3f}, 1'b0);
        rd(24'h350c3f);
        seeOut(24'h350c3f);
        $display("unused bits test done");
        wr(8'hd4, 0, 40'h0, 1'b1);
        seeOut(24'h350c3f);
        $display("wrong address test done");
        wr(8'hd2, 3, {16'h0003, 8'hc0, 16'h0}, 1'b0);
        rd(24'hc00c3f);
        seeOut(24'hc00c3f);
        $display("short write test done");
        // a repeated start after the command byte restarts at the byte count
        u_bus_master_model.start();
        u_bus_master_model.xb(8'hd2, 1'b1, rb, kb);
        chk(16'(kb), 16'h0);
        u_bus_master_model.xb(8'h00, 1'b1, rb, kb);
        chk(16'(kb), 16'h0);
        u_bus_master_model.rstart();
        rd(24'hc00c3f);
        seeOut(24'hc00c3f);
        $display("repeated start test done");
        end_of_test;
    end
    // hang guard, about three times the expected run
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_of_test;
        end
    end
endmodule // clock_fanout_i2c_output_enable_tb_top
